// >>> hw/pcsf_defines.svh
// Register offsets, field positions, reset values for the pause/control filter
`ifndef PCSF_DEFINES_SVH
`define PCSF_DEFINES_SVH
`define PCSF_ADDR_W 8
`define PCSF_REG_CTRL 8'h00
`define PCSF_REG_PAUSE_EN 8'h04
`define PCSF_REG_UC_DA_LO 8'h08
`define PCSF_REG_UC_DA_HI 8'h0c
`define PCSF_REG_MC_DA_LO 8'h10
`define PCSF_REG_MC_DA_HI 8'h14
`define PCSF_REG_SA_LO 8'h18
`define PCSF_REG_SA_HI 8'h1c
`define PCSF_REG_ETYPE 8'h20
`define PCSF_REG_OPCODE 8'h24
`define PCSF_REG_IRQ_STAT 8'h28
`define PCSF_REG_IRQ_MASK 8'h2c
`define PCSF_REG_PAUSE_STAT 8'h30
`define PCSF_CTRL_FWD 0
`define PCSF_CTRL_CHK_ACK 1
`define PCSF_CTRL_GCP_EN 2
`define PCSF_CTRL_CHK_UC 3
`define PCSF_CTRL_CHK_MC 4
`define PCSF_CTRL_CHK_SA 5
`define PCSF_CTRL_CHK_ETYPE 6
`define PCSF_CTRL_CHK_OPC 7
`define PCSF_CTRL_W 8
`define PCSF_CTRL_RST 8'h00
`define PCSF_PAUSE_EN_RST 9'h1ff
`define PCSF_ETYPE_RST 16'h8808
`define PCSF_OPC_MIN_RST 16'h0001
`define PCSF_OPC_MAX_RST 16'h0001
`define PCSF_IRQ_TX_PAUSE 0
`define PCSF_IRQ_RX_DROP 1
`define PCSF_IRQ_GCP 2
`define PCSF_IRQ_RX_PAUSE 3
`define PCSF_IRQ_W 4
`define PCSF_GLOBAL_BIT 8
`define PCSF_RESP_OKAY 2'b00
`define PCSF_RESP_SLVERR 2'b10
`endif

// >>> hw/pcsf_pkg.sv
// Types shared by the pause/control filter
package pcsf_pkg;
  typedef enum logic [1:0] {
    PCSF_DA_UNI = 2'b00,
    PCSF_DA_MULTI = 2'b01,
    PCSF_DA_BCAST = 2'b11
  } pcsf_da_kind_t;
  typedef enum logic [1:0] {
    PCSF_PZ_NONE = 2'b00,
    PCSF_PZ_GLOBAL = 2'b01,
    PCSF_PZ_PRIO = 2'b11
  } pcsf_pause_kind_t;
  typedef struct packed {
    logic fcs_good;
    pcsf_da_kind_t da_kind;
    logic vlan;
    pcsf_pause_kind_t pause_kind;
    logic [2:0] pause_pri;
  } pcsf_tx_info_t;
  typedef struct packed {
    logic is_ctrl;
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
  } pcsf_rx_hdr_t;
endpackage

// >>> hw/pcsf_top.sv
// Pause and control-frame statistics, filter and register block
`include "pcsf_defines.svh"
module pcsf_top import pcsf_pkg::*; #(
  parameter bit RX_FC_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // AXI4-Lite slave
  input wire logic [`PCSF_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [`PCSF_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Transmit frame completion from the MAC
  input wire logic TX_DONE,
  input wire pcsf_tx_info_t TX_INFO,
  // Transmit statistics
  output logic [8:0] STAT_TX_PAUSE_VALID,
  output logic STAT_TX_UNICAST,
  output logic STAT_TX_MULTICAST,
  output logic STAT_TX_BROADCAST,
  output logic STAT_TX_VLAN,
  output logic STAT_TX_PAUSE,
  output logic STAT_TX_USER_PAUSE,
  // Receive header and pause events from the MAC
  input wire logic RX_HDR_VALID,
  input wire pcsf_rx_hdr_t RX_HDR,
  input wire logic RX_PAUSE_IN,
  input wire logic [8:0] RX_PAUSE_PRI,
  // Receive decisions and pause handshake
  output logic RX_FWD,
  output logic RX_DROP,
  output logic RX_GCP_MATCH,
  output logic [8:0] RX_PAUSE_REQ,
  output logic [8:0] RX_USER_PAUSE,
  input wire logic [8:0] RX_PAUSE_ACK,
  // Interrupt
  output logic IRQ
);

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Configuration registers
  logic [`PCSF_CTRL_W-1:0] ctrl_ff;
  logic [8:0] pause_en_ff;
  logic [47:0] uc_da_ff;
  logic [47:0] mc_da_ff;
  logic [47:0] sa_ff;
  logic [15:0] etype_ff;
  logic [15:0] opc_min_ff;
  logic [15:0] opc_max_ff;
  logic [`PCSF_IRQ_W-1:0] irq_stat_ff;
  logic [`PCSF_IRQ_W-1:0] irq_mask_ff;
  logic [8:0] pend_ff;
  logic [8:0] nxt_pend;
  logic [`PCSF_IRQ_W-1:0] nxt_irq_mask;

  // Write channel
  logic aw_got_ff;
  logic w_got_ff;
  logic [`PCSF_ADDR_W-1:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic wr_hit;
  logic nxt_aw_got;
  logic nxt_w_got;
  logic nxt_bvalid;

  assign aw_hs = AWVALID & AWREADY;
  assign w_hs = WVALID & WREADY;
  // Write lands one cycle after both halves are held, so no bypass path is needed
  assign wr_fire = aw_got_ff & w_got_ff & ~BVALID;
  assign nxt_aw_got = wr_fire ? 1'b0 : (aw_got_ff | aw_hs);
  assign nxt_w_got = wr_fire ? 1'b0 : (w_got_ff | w_hs);
  assign nxt_bvalid = wr_fire | (BVALID & ~BREADY);

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `PCSF_RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      if (aw_hs) begin
        waddr_ff <= AWADDR;
      end
      if (w_hs) begin
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      AWREADY <= ~nxt_aw_got & ~nxt_bvalid;
      WREADY <= ~nxt_w_got & ~nxt_bvalid;
      BVALID <= nxt_bvalid;
      if (wr_fire) begin
        BRESP <= wr_hit ? `PCSF_RESP_OKAY : `PCSF_RESP_SLVERR;
      end
    end
  end

  always_comb begin
    unique case (waddr_ff)
      `PCSF_REG_CTRL, `PCSF_REG_PAUSE_EN, `PCSF_REG_UC_DA_LO, `PCSF_REG_UC_DA_HI,
      `PCSF_REG_MC_DA_LO, `PCSF_REG_MC_DA_HI, `PCSF_REG_SA_LO, `PCSF_REG_SA_HI,
      `PCSF_REG_ETYPE, `PCSF_REG_OPCODE, `PCSF_REG_IRQ_STAT, `PCSF_REG_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Settings live in registers; no loose pins for them
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl_ff <= `PCSF_CTRL_RST;
      pause_en_ff <= `PCSF_PAUSE_EN_RST;
      uc_da_ff <= '0;
      mc_da_ff <= '0;
      sa_ff <= '0;
      etype_ff <= `PCSF_ETYPE_RST;
      opc_min_ff <= `PCSF_OPC_MIN_RST;
      opc_max_ff <= `PCSF_OPC_MAX_RST;
      irq_mask_ff <= '0;
    end else if (wr_fire) begin
      unique case (waddr_ff)
        `PCSF_REG_CTRL: ctrl_ff <= 8'(apply_strb(32'(ctrl_ff), wdata_ff, wstrb_ff));
        `PCSF_REG_PAUSE_EN: pause_en_ff <= 9'(apply_strb(32'(pause_en_ff), wdata_ff, wstrb_ff));
        `PCSF_REG_UC_DA_LO: uc_da_ff[31:0] <= apply_strb(uc_da_ff[31:0], wdata_ff, wstrb_ff);
        `PCSF_REG_UC_DA_HI: uc_da_ff[47:32] <= 16'(apply_strb(32'(uc_da_ff[47:32]), wdata_ff,
                                                              wstrb_ff));
        `PCSF_REG_MC_DA_LO: mc_da_ff[31:0] <= apply_strb(mc_da_ff[31:0], wdata_ff, wstrb_ff);
        `PCSF_REG_MC_DA_HI: mc_da_ff[47:32] <= 16'(apply_strb(32'(mc_da_ff[47:32]), wdata_ff,
                                                              wstrb_ff));
        `PCSF_REG_SA_LO: sa_ff[31:0] <= apply_strb(sa_ff[31:0], wdata_ff, wstrb_ff);
        `PCSF_REG_SA_HI: sa_ff[47:32] <= 16'(apply_strb(32'(sa_ff[47:32]), wdata_ff, wstrb_ff));
        `PCSF_REG_ETYPE: etype_ff <= 16'(apply_strb(32'(etype_ff), wdata_ff, wstrb_ff));
        `PCSF_REG_OPCODE: {opc_max_ff, opc_min_ff} <= apply_strb({opc_max_ff, opc_min_ff},
                                                                 wdata_ff, wstrb_ff);
        `PCSF_REG_IRQ_MASK: irq_mask_ff <= nxt_irq_mask;
        default: ;
      endcase
    end
  end

  // Read channel
  logic nxt_rvalid;
  logic ar_hs;
  logic [31:0] nxt_rdata;
  logic rd_hit;

  assign ar_hs = ARVALID & ARREADY;
  assign nxt_rvalid = ar_hs | (RVALID & ~RREADY);

  always_comb begin
    rd_hit = 1'b1;
    unique case (ARADDR)
      `PCSF_REG_CTRL: nxt_rdata = 32'(ctrl_ff);
      `PCSF_REG_PAUSE_EN: nxt_rdata = 32'(pause_en_ff);
      `PCSF_REG_UC_DA_LO: nxt_rdata = uc_da_ff[31:0];
      `PCSF_REG_UC_DA_HI: nxt_rdata = 32'(uc_da_ff[47:32]);
      `PCSF_REG_MC_DA_LO: nxt_rdata = mc_da_ff[31:0];
      `PCSF_REG_MC_DA_HI: nxt_rdata = 32'(mc_da_ff[47:32]);
      `PCSF_REG_SA_LO: nxt_rdata = sa_ff[31:0];
      `PCSF_REG_SA_HI: nxt_rdata = 32'(sa_ff[47:32]);
      `PCSF_REG_ETYPE: nxt_rdata = 32'(etype_ff);
      `PCSF_REG_OPCODE: nxt_rdata = {opc_max_ff, opc_min_ff};
      `PCSF_REG_IRQ_STAT: nxt_rdata = 32'(irq_stat_ff);
      `PCSF_REG_IRQ_MASK: nxt_rdata = 32'(irq_mask_ff);
      `PCSF_REG_PAUSE_STAT: nxt_rdata = 32'(pend_ff);
      default: begin
        nxt_rdata = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= `PCSF_RESP_OKAY;
    end else begin
      ARREADY <= ~nxt_rvalid;
      RVALID <= nxt_rvalid;
      if (ar_hs) begin
        RDATA <= nxt_rdata;
        RRESP <= rd_hit ? `PCSF_RESP_OKAY : `PCSF_RESP_SLVERR;
      end
    end
  end

  // Transmit statistics: one-cycle pulses registered one cycle after the completion strobe
  logic tx_good;
  logic tx_gpause;
  logic tx_ppause;
  assign tx_good = TX_DONE & TX_INFO.fcs_good;
  assign tx_gpause = tx_good & (TX_INFO.pause_kind == PCSF_PZ_GLOBAL);
  assign tx_ppause = tx_good & (TX_INFO.pause_kind == PCSF_PZ_PRIO);

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      STAT_TX_UNICAST <= 1'b0;
      STAT_TX_MULTICAST <= 1'b0;
      STAT_TX_BROADCAST <= 1'b0;
      STAT_TX_VLAN <= 1'b0;
      STAT_TX_PAUSE <= 1'b0;
      STAT_TX_USER_PAUSE <= 1'b0;
      STAT_TX_PAUSE_VALID <= 9'h000;
    end else begin
      STAT_TX_UNICAST <= tx_good & (TX_INFO.da_kind == PCSF_DA_UNI);
      STAT_TX_MULTICAST <= tx_good & (TX_INFO.da_kind == PCSF_DA_MULTI);
      STAT_TX_BROADCAST <= tx_good & (TX_INFO.da_kind == PCSF_DA_BCAST);
      STAT_TX_VLAN <= tx_good & TX_INFO.vlan;
      STAT_TX_PAUSE <= tx_gpause;
      STAT_TX_USER_PAUSE <= tx_ppause;
      STAT_TX_PAUSE_VALID <= 9'h000;
      if (tx_gpause) begin
        STAT_TX_PAUSE_VALID[`PCSF_GLOBAL_BIT] <= 1'b1;
      end
      if (tx_ppause) begin
        STAT_TX_PAUSE_VALID[TX_INFO.pause_pri] <= 1'b1;
      end
    end
  end

  // Global control frame match
  logic da_chk;
  logic da_ok;
  logic gcp_hit;
  logic ctrl_frame;
  assign da_chk = ctrl_ff[`PCSF_CTRL_CHK_UC] | ctrl_ff[`PCSF_CTRL_CHK_MC];
  // Either enabled destination may match; unicast and multicast are alternatives
  assign da_ok = ~da_chk
    | (ctrl_ff[`PCSF_CTRL_CHK_UC] & (RX_HDR.da == uc_da_ff))
    | (ctrl_ff[`PCSF_CTRL_CHK_MC] & (RX_HDR.da == mc_da_ff));
  assign gcp_hit = ctrl_ff[`PCSF_CTRL_GCP_EN] & da_ok
    & (~ctrl_ff[`PCSF_CTRL_CHK_SA] | (RX_HDR.sa == sa_ff))
    & (~ctrl_ff[`PCSF_CTRL_CHK_ETYPE] | (RX_HDR.etype == etype_ff))
    & (~ctrl_ff[`PCSF_CTRL_CHK_OPC]
       | ((RX_HDR.opcode >= opc_min_ff) & (RX_HDR.opcode <= opc_max_ff)));
  assign ctrl_frame = RX_HDR.is_ctrl | gcp_hit;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      RX_FWD <= 1'b0;
      RX_DROP <= 1'b0;
      RX_GCP_MATCH <= 1'b0;
    end else begin
      RX_FWD <= RX_FC_PRESENT & RX_HDR_VALID
        & (~ctrl_frame | ctrl_ff[`PCSF_CTRL_FWD]);
      RX_DROP <= RX_FC_PRESENT & RX_HDR_VALID & ctrl_frame & ~ctrl_ff[`PCSF_CTRL_FWD];
      RX_GCP_MATCH <= RX_FC_PRESENT & RX_HDR_VALID & gcp_hit;
    end
  end

  // Pause requests; with wait-for-ack they stand until the user acknowledges
  always_comb begin
    nxt_pend = ctrl_ff[`PCSF_CTRL_CHK_ACK] ? (pend_ff & ~RX_PAUSE_ACK) : 9'h000;
    if (RX_PAUSE_IN) begin
      nxt_pend = nxt_pend | RX_PAUSE_PRI;
    end
    if (!RX_FC_PRESENT) begin
      nxt_pend = 9'h000;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pend_ff <= 9'h000;
      RX_PAUSE_REQ <= 9'h000;
      RX_USER_PAUSE <= 9'h000;
    end else begin
      pend_ff <= nxt_pend;
      RX_PAUSE_REQ <= nxt_pend;
      // Enable masks only the user copy; internal pause state keeps running
      RX_USER_PAUSE <= nxt_pend & pause_en_ff;
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  logic [`PCSF_IRQ_W-1:0] irq_set;
  logic [`PCSF_IRQ_W-1:0] irq_clr;
  logic [`PCSF_IRQ_W-1:0] nxt_irq_stat;
  assign irq_set = {RX_FC_PRESENT & RX_PAUSE_IN & (|RX_PAUSE_PRI),
                    RX_FC_PRESENT & RX_HDR_VALID & gcp_hit,
                    RX_FC_PRESENT & RX_HDR_VALID & ctrl_frame & ~ctrl_ff[`PCSF_CTRL_FWD],
                    tx_gpause | tx_ppause};
  assign irq_clr = (wr_fire && waddr_ff == `PCSF_REG_IRQ_STAT) ?
                   4'(apply_strb(32'h0, wdata_ff, wstrb_ff)) : '0;
  // Level follows the mask as it will stand, so a mask write moves IRQ in step
  assign nxt_irq_mask = (wr_fire && waddr_ff == `PCSF_REG_IRQ_MASK) ?
                        4'(apply_strb(32'(irq_mask_ff), wdata_ff, wstrb_ff)) : irq_mask_ff;
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      irq_stat_ff <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      IRQ <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_pause_taken;
    RX_PAUSE_IN && RX_PAUSE_PRI[8] && ctrl_ff[`PCSF_CTRL_CHK_ACK];
  endsequence
  sequence s_no_ack;
    !RX_PAUSE_ACK[8] && ctrl_ff[`PCSF_CTRL_CHK_ACK];
  endsequence
  sequence s_wr_pair;
    aw_got_ff && w_got_ff && !BVALID;
  endsequence

  a_tx_uc_pulse: assert property (tx_good && TX_INFO.da_kind == PCSF_DA_UNI
    |=> STAT_TX_UNICAST) else $error("unicast stat missing");
  a_stat_one_frame: assert property (STAT_TX_VLAN |-> $past(TX_DONE)
    && $past(TX_INFO.vlan)) else $error("vlan stat without frame");
  a_tx_global_bit: assert property (tx_gpause |=> STAT_TX_PAUSE_VALID[8]
    && STAT_TX_PAUSE) else $error("global pause flag missing");
  a_tx_prio_pause: assert property (STAT_TX_USER_PAUSE |-> $past(tx_ppause)
    && STAT_TX_PAUSE_VALID[8:0] != 9'h000) else $error("priority pause stat wrong");
  a_ctrl_drop: assert property (RX_HDR_VALID && RX_HDR.is_ctrl
    && !ctrl_ff[`PCSF_CTRL_FWD] |=> RX_DROP && !RX_FWD) else $error("control frame not dropped");
  a_ack_hold: assert property (s_pause_taken ##1 s_no_ack
    |-> RX_PAUSE_REQ[8] ##1 RX_PAUSE_REQ[8]) else $error("pause request lost before ack");
  a_no_ack_mode: assert property (!ctrl_ff[`PCSF_CTRL_CHK_ACK] && !RX_PAUSE_IN
    |=> RX_PAUSE_REQ == 9'h000) else $error("request held without ack mode");
  a_user_gate: assert property (RX_USER_PAUSE == (RX_PAUSE_REQ & $past(pause_en_ff)))
    else $error("user pause not gated by enable");
  a_sa_miss: assert property (RX_HDR_VALID && ctrl_ff[`PCSF_CTRL_CHK_SA]
    && RX_HDR.sa != sa_ff |=> !RX_GCP_MATCH) else $error("source mismatch matched");
  a_opc_range: assert property (RX_HDR_VALID && ctrl_ff[`PCSF_CTRL_CHK_OPC]
    && RX_HDR.opcode > opc_max_ff |=> !RX_GCP_MATCH) else $error("opcode above max matched");
  a_gcp_off: assert property (!ctrl_ff[`PCSF_CTRL_GCP_EN] |=> !RX_GCP_MATCH)
    else $error("match while disabled");
  a_irq_level: assert property (IRQ == |(irq_stat_ff & irq_mask_ff))
    else $error("interrupt level wrong");
  a_wr_resp: assert property (s_wr_pair |=> BVALID) else $error("no write response");

endmodule

// >>> bench/pcsf_user_ack.sv
// Client-side model that acknowledges pending pause requests
module pcsf_user_ack (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pause handshake
  input wire logic [8:0] req,
  input wire logic [2:0] dly,
  output logic [8:0] ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff;
  // Waits dly cycles so both prompt and slow clients are exercised
  always @(posedge clk) begin
    if (rst || req == 9'h000) begin
      cnt_ff <= 3'h0;
      ack <= 9'h000;
    end else if (cnt_ff == dly) begin
      ack <= req;
      cnt_ff <= 3'h0;
    end else begin
      ack <= 9'h000;
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
endmodule

// >>> bench/test_pause_ctrl_stats_filter.sv
// Self-checking bench for the pause/control filter block
module test_pause_ctrl_stats_filter import pcsf_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0, RESET = 1'b1;
  logic [7:0] AWADDR, ARADDR;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic TX_DONE, RX_HDR_VALID, RX_PAUSE_IN, IRQ, RX_FWD, RX_DROP, RX_GCP_MATCH;
  pcsf_tx_info_t TX_INFO;
  pcsf_rx_hdr_t RX_HDR;
  logic [8:0] RX_PAUSE_PRI, RX_PAUSE_REQ, RX_USER_PAUSE, ack_w, STAT_TX_PAUSE_VALID;
  wire [5:0] tx_cnt;
  int seed = 16810;
  int failures = 0;
  int compares = 0;
  logic run = 1'b0;
  logic [7:0] ctrl = 8'h00;
  logic [8:0] pen = 9'h1ff;
  logic [47:0] uc = 48'h0, mc = 48'h0, sa = 48'h0;
  logic [15:0] et = 16'h8808, omin = 16'h0001, omax = 16'h0001;
  logic [3:0] mask = 4'h0, e_stat = 4'h0;
  logic [5:0] e_tx = 6'h00;
  logic [8:0] e_pv = 9'h000, e_req = 9'h000, e_usr = 9'h000;
  logic [2:0] e_rx = 3'h0, dly = 3'h0;
  logic g, gm, fwd;

  always #5 MCLK = ~MCLK;

  pcsf_top pcsf_top_inst (.MCLK(MCLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TX_DONE(TX_DONE), .TX_INFO(TX_INFO), .STAT_TX_PAUSE_VALID(STAT_TX_PAUSE_VALID),
    .STAT_TX_UNICAST(tx_cnt[5]), .STAT_TX_MULTICAST(tx_cnt[4]), .STAT_TX_BROADCAST(tx_cnt[3]),
    .STAT_TX_VLAN(tx_cnt[2]), .STAT_TX_PAUSE(tx_cnt[1]), .STAT_TX_USER_PAUSE(tx_cnt[0]),
    .RX_HDR_VALID(RX_HDR_VALID), .RX_HDR(RX_HDR), .RX_PAUSE_IN(RX_PAUSE_IN),
    .RX_PAUSE_PRI(RX_PAUSE_PRI), .RX_FWD(RX_FWD), .RX_DROP(RX_DROP),
    .RX_GCP_MATCH(RX_GCP_MATCH), .RX_PAUSE_REQ(RX_PAUSE_REQ), .RX_USER_PAUSE(RX_USER_PAUSE),
    .RX_PAUSE_ACK(ack_w), .IRQ(IRQ));

  pcsf_user_ack pcsf_user_ack_inst (.clk(MCLK), .rst(RESET), .req(RX_PAUSE_REQ), .dly(dly),
    .ack(ack_w));

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (exp !== got) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  function automatic logic gcp(pcsf_rx_hdr_t h);
    logic d;
    d = (!ctrl[3] && !ctrl[4]) || (ctrl[3] && h.da == uc) || (ctrl[4] && h.da == mc);
    return ctrl[2] && d && (!ctrl[5] || h.sa == sa) && (!ctrl[6] || h.etype == et) &&
      (!ctrl[7] || (h.opcode >= omin && h.opcode <= omax));
  endfunction

  // Outputs seen at an edge answer the inputs of the edge before
  always @(posedge MCLK) begin
    if (run) begin
      chk("tx_pause_valid", e_pv, STAT_TX_PAUSE_VALID);
      chk("tx_counts", e_tx, tx_cnt);
      chk("rx_decision", e_rx, {RX_FWD, RX_DROP, RX_GCP_MATCH});
      chk("pause_req", e_req, RX_PAUSE_REQ);
      chk("user_pause", e_usr, RX_USER_PAUSE);
    end
    g = TX_DONE && TX_INFO.fcs_good;
    e_tx = {g && TX_INFO.da_kind == PCSF_DA_UNI, g && TX_INFO.da_kind == PCSF_DA_MULTI,
      g && TX_INFO.da_kind == PCSF_DA_BCAST, g && TX_INFO.vlan,
      g && TX_INFO.pause_kind == PCSF_PZ_GLOBAL, g && TX_INFO.pause_kind == PCSF_PZ_PRIO};
    e_pv = 9'h000;
    if (e_tx[1])
      e_pv[8] = 1'b1;
    if (e_tx[0])
      e_pv[TX_INFO.pause_pri] = 1'b1;
    gm = RX_HDR_VALID && gcp(RX_HDR);
    fwd = !(RX_HDR.is_ctrl || gm) || ctrl[0];
    e_rx = RX_HDR_VALID ? {fwd, !fwd, gm} : 3'h0;
    e_stat = e_stat | {RX_PAUSE_IN && RX_PAUSE_PRI != 9'h000, gm, RX_HDR_VALID && !fwd,
      e_pv != 9'h000};
    e_req = (RX_PAUSE_IN ? RX_PAUSE_PRI : 9'h000) | (ctrl[1] ? e_req & ~ack_w : 9'h000);
    e_usr = e_req & pen;
  end

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int n;
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hf;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
      if (BVALID && aw && w)
        break;
      if (AWREADY && !aw) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (WREADY && !w) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end while (n < 50);
    BREADY <= 1'b0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
    chk("bresp", er, BRESP);
    if (er == 2'b00) begin
      case (a)
        8'h00: ctrl = d[7:0];
        8'h04: pen = d[8:0];
        8'h08: uc[31:0] = d;
        8'h0c: uc[47:32] = d[15:0];
        8'h10: mc[31:0] = d;
        8'h14: mc[47:32] = d[15:0];
        8'h18: sa[31:0] = d;
        8'h1c: sa[47:32] = d[15:0];
        8'h20: et = d[15:0];
        8'h24: {omax, omin} = d;
        8'h28: e_stat = e_stat & ~d[3:0];
        8'h2c: mask = d[3:0];
        default: ;
      endcase
    end
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp, logic [1:0] er);
    int n;
    logic ar;
    ar = 1'b0;
    n = 0;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
      if (RVALID && ar)
        break;
      if (ARREADY && !ar) begin
        ar = 1'b1;
        ARVALID <= 1'b0;
      end
    end while (n < 50);
    RREADY <= 1'b0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
    chk("rdata", exp, RDATA);
    chk("rresp", er, RRESP);
  endtask

  // Random back-to-back frames on both paths, then a quiet tail to let pauses drain
  task automatic traffic(int n);
    logic [31:0] r;
    pcsf_tx_info_t t;
    pcsf_rx_hdr_t h;
    repeat (n) begin
      @(posedge MCLK);
      r = $random(seed);
      t = '{r[7] | r[8], pcsf_da_kind_t'({r[1], r[1] | r[0]}), r[9],
        pcsf_pause_kind_t'({r[3], r[3] | r[2]}), r[6:4]};
      TX_DONE <= r[10];
      TX_INFO <= t;
      r = $random(seed);
      h.is_ctrl = r[0];
      h.da = r[2:1] == 2'h0 ? uc : r[2:1] == 2'h1 ? mc : {r[31:16], 32'($random(seed))};
      h.sa = r[3] ? sa : {r[31:16], 32'($random(seed))};
      h.etype = r[4] ? et : r[31:16];
      h.opcode = {13'h0, r[7:5]};
      RX_HDR_VALID <= r[8];
      RX_HDR <= h;
      RX_PAUSE_IN <= r[9] & r[10];
      RX_PAUSE_PRI <= 9'($random(seed));
    end
    @(posedge MCLK);
    TX_DONE <= 1'b0;
    RX_HDR_VALID <= 1'b0;
    RX_PAUSE_IN <= 1'b0;
    repeat (16) @(posedge MCLK);
  endtask

  initial begin
    {AWADDR, ARADDR, AWVALID, WVALID, BREADY, ARVALID, RREADY, WDATA, WSTRB} = '0;
    {TX_DONE, RX_HDR_VALID, RX_PAUSE_IN, RX_PAUSE_PRI} = '0;
    TX_INFO = '0;
    RX_HDR = '0;
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    run = 1'b1;
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h04, 32'h1ff, 2'b00);
    rd(8'h20, 32'h8808, 2'b00);
    rd(8'h24, 32'h00010001, 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    wr(8'h40, 32'h1, 2'b10);
    wr(8'h30, 32'h1, 2'b10);
    $display("test registers done");
    for (int a = 8; a < 32; a += 4)
      wr(8'(a), $random(seed), 2'b00);
    wr(8'h20, 32'($random(seed)), 2'b00);
    wr(8'h24, 32'h00040002, 2'b00);
    for (int p = 0; p < 10; p++) begin
      dly = 3'(p);
      wr(8'h04, 32'($random(seed)), 2'b00);
      wr(8'h00, {24'h0, 8'($random(seed)) | 8'h04} ^ {30'h0, p[0], 1'b0}, 2'b00);
      traffic(80);
    end
    $display("test traffic done");
    rd(8'h30, {23'h0, e_req}, 2'b00);
    rd(8'h28, {28'h0, e_stat}, 2'b00);
    chk("irq_masked", 1'b0, IRQ);
    wr(8'h2c, 32'hf, 2'b00);
    repeat (2) @(posedge MCLK);
    chk("irq_on", |(e_stat & mask), IRQ);
    wr(8'h28, 32'hf, 2'b00);
    repeat (2) @(posedge MCLK);
    rd(8'h28, 32'h0, 2'b00);
    chk("irq_off", 1'b0, IRQ);
    @(posedge MCLK);
    TX_DONE <= 1'b1;
    TX_INFO <= '{1'b1, PCSF_DA_MULTI, 1'b0, PCSF_PZ_GLOBAL, 3'h0};
    @(posedge MCLK);
    TX_DONE <= 1'b0;
    repeat (3) @(posedge MCLK);
    chk("irq_event", 1'b1, IRQ);
    $display("test interrupt done");
    summarize();
  end
endmodule
